// file: sahi_pkg.sv
package sahi_pkg;
  localparam int RES_W = 12;
  localparam int BUS_W = 8;
  localparam int CONV_CYCLES = 80;
  localparam int SCLK_HALF = 2;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] SAMPLE_RST = 12'h000;
  localparam logic [6:0] SYNC_RST = 7'h60;
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam int HI_MSB = 11;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  typedef enum logic [1:0] {
    SAHI_IDLE = 2'b00,
    SAHI_CONV = 2'b01
  } sahi_state_t;
endpackage

// file: sahi_top.sv
// Operation
// R1: Result coding is straight binary or two's complement per format select.
// R2: Clock source low drives bit clock out; high takes it from host.
// R3: Byte select low puts result bits 11..4 on the parallel lines.
// R4: Byte select high puts bits 3..0 high, lower four lines low.
// R5: Parallel lines float when chip select high or read/convert low.
// R6: Serial result shifts out in step with the serial bit clock.
// R7: Cascade input is taken only with an external bit clock.
// R8: Strobe fall with chip select low and not busy starts conversion.
// R9: Strobe rise with chip select low enables parallel drivers.
// R10: Chip select ORed with strobe; its fall with strobe low starts conversion.
// R11: Internal clock: starting edge also begins sending previous result.
// R12: Busy low from start until conversion done and outputs updated.
// R13: Power-down stops analog parts except reference; logic keeps running.
// R14: Reference disable turns internal reference off; host supplies external one.
// R15: Format select high gives straight binary, low gives two's complement.
// R16: Serial sends twelve bits MSB first, valid on both clock edges.
// R17: Requests while busy are ignored.
// R18: Host raises chip select or strobe before busy rises.
// R19: Conversion time is a fixed parameter count of clock cycles; with internal clock the code takes at least 49 for the frame.
// R20: Byte select switches bus halves without converting or changing result.
module sahi_top
  import sahi_pkg::*;
#(
  parameter int CONV_CYC = sahi_pkg::CONV_CYCLES
)(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_chip_select_n,
  input wire logic i_read_convert_n,
  input wire logic i_byte_select,
  input wire logic i_output_format_select,
  input wire logic i_serial_clock_source_select,
  input wire logic i_serial_bit_clock,
  input wire logic i_cascade_in,
  input wire logic i_analog_power_down,
  input wire logic i_reference_disable,
  input wire logic [sahi_pkg::RES_W-1:0] i_sample,
  output logic [sahi_pkg::BUS_W-1:0] o_parallel_line,
  output logic o_parallel_oe,
  output logic o_busy_n,
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe,
  output logic o_serial_result_out,
  output logic o_analog_enable,
  output logic o_reference_enable
);
  // The conversion counter is twelve bits wide
  if (CONV_CYC < 30 || CONV_CYC > 4095)
  begin
    $error("CONV_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage is only read by the second
  logic [6:0] s1_q, s2_q, s3_q, s1_d;
  logic [1:0] ctl1_q, ctl2_q;
  always_comb s1_d = {i_chip_select_n, i_read_convert_n, i_byte_select, i_output_format_select,
                      i_serial_clock_source_select, i_serial_bit_clock, i_cascade_in};
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      // Idle pin levels, so no false edge is seen just after reset
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      ctl1_q <= 2'h0;
      ctl2_q <= 2'h0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      ctl1_q <= {i_analog_power_down, i_reference_disable};
      ctl2_q <= ctl1_q;
    end
  end
  logic cs_n, rc_n, byte_sel, fmt_sb, ext_clk, xclk, cas, xclk_prev;
  logic req, req_prev;
  always_comb
  begin
    cs_n = s2_q[6];
    rc_n = s2_q[5];
    byte_sel = s2_q[4];
    fmt_sb = s2_q[3];
    ext_clk = s2_q[2];
    xclk = s2_q[1];
    cas = s2_q[0];
    xclk_prev = s3_q[1];
    req = !(s2_q[6] | s2_q[5]);      // R10
    req_prev = !(s3_q[6] | s3_q[5]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion and serial engine
  sahi_state_t st_q, st_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] res_q, res_d, sh_q, sh_d;
  logic [3:0] bits_q, bits_d;
  logic [1:0] div_q, div_d;
  logic clk_q, clk_d, sd_q, sd_d, busy_q, busy_d, tx_q, tx_d;
  logic start, bus_on_q, bus_on_d;
  logic [11:0] coded;

  always_comb
  begin
    // Straight binary flips the sign bit of the two's complement sample
    coded = fmt_sb ? (i_sample ^ SIGN_FLIP) : i_sample; // R1 R15
    start = req && !req_prev && st_q == SAHI_IDLE;       // R8 R10 R17
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    sh_d = sh_q;
    bits_d = bits_q;
    div_d = div_q;
    clk_d = clk_q;
    sd_d = sd_q;
    busy_d = busy_q;
    tx_d = tx_q;
    unique case (st_q)
      SAHI_IDLE:
      begin
        if (start)
        begin
          st_d = SAHI_CONV;
          busy_d = 1'b0;                                  // R12
          cnt_d = 12'(CONV_CYC);                          // R19
          sh_d = {res_q[10:0], 1'b0};
          sd_d = res_q[11];                               // R16
          tx_d = !ext_clk;                                // R11
          bits_d = 4'(RES_W);
          div_d = 2'h0;
          clk_d = 1'b0;
        end
      end
      SAHI_CONV:
      begin
        // Count stops at one so a long serial frame cannot wrap it
        if (cnt_q != 12'h001)
          cnt_d = cnt_q - 12'h001;                        // R19
        if (tx_q)
        begin
          // Internal clock: divider makes the bit clock, new bit on falling edge
          if (div_q == 2'(SCLK_HALF - 1))
          begin
            div_d = 2'h0;
            clk_d = !clk_q;
            if (clk_q)
            begin
              if (bits_q == 4'h1)
                tx_d = 1'b0;
              else
              begin
                sd_d = sh_q[11];                          // R6
                sh_d = {sh_q[10:0], 1'b0};
              end
              bits_d = bits_q - 4'h1;
            end
          end
          else
            div_d = div_q + 2'h1;
        end
        if (cnt_q == 12'h001 && !tx_q)
        begin
          st_d = SAHI_IDLE;
          res_d = coded;
          busy_d = 1'b1;                                  // R12
        end
      end
      default:
        st_d = SAHI_IDLE;
    endcase
    // External clock: shift on host falling edge, cascade fills behind
    if (ext_clk && xclk_prev && !xclk && !start)
    begin
      sd_d = sh_q[11];                                    // R6 R2
      sh_d = {sh_q[10:0], cas};                           // R7
    end
  end

  always_comb
  begin
    // Drivers switch on only at a strobe rise with select low, off at once
    bus_on_d = bus_on_q;
    if (cs_n || !rc_n)
      bus_on_d = 1'b0;                                    // R5
    else if (req_prev)
      bus_on_d = 1'b1;                                    // R9
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q <= SAHI_IDLE;
      cnt_q <= 12'h000;
      res_q <= RESULT_RST;
      sh_q <= SAMPLE_RST;
      bits_q <= 4'h0;
      div_q <= 2'h0;
      clk_q <= 1'b0;
      sd_q <= 1'b0;
      busy_q <= 1'b1;
      tx_q <= 1'b0;
      bus_on_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      div_q <= div_d;
      clk_q <= clk_d;
      sd_q <= sd_d;
      busy_q <= busy_d;
      tx_q <= tx_d;
      bus_on_q <= bus_on_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers; byte select only steers the view, never the result
  logic [7:0] par_d;
  always_comb
  begin
    if (byte_sel)
      par_d = {res_d[LO_MSB:LO_LSB], 4'h0};              // R4 R20 R12
    else
      par_d = res_d[HI_MSB:HI_LSB];                       // R3 R20 R12
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_parallel_line <= 8'h00;
      o_parallel_oe <= 1'b0;
      o_busy_n <= 1'b1;
      o_serial_bit_clock <= 1'b0;
      o_serial_bit_clock_oe <= 1'b0;
      o_serial_result_out <= 1'b0;
      o_analog_enable <= 1'b0;
      o_reference_enable <= 1'b0;
    end
    else
    begin
      o_parallel_line <= par_d;
      o_parallel_oe <= bus_on_d;                          // R5 R9
      o_busy_n <= busy_d;                                 // R12
      o_serial_bit_clock <= clk_d;
      o_serial_bit_clock_oe <= !ext_clk;                  // R2
      o_serial_result_out <= sd_d;                        // R16
      // Pins are async, so these pass the two-stage sync first
      o_analog_enable <= !ctl2_q[1];                      // R13
      o_reference_enable <= !ctl2_q[0];                   // R14
    end
  end
endmodule

// file: sahi_host_clk.sv
module sahi_host_clk (
  input wire logic i_run,
  output logic o_clk,
  output logic o_cascade
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_clk = 1'b0;
    o_cascade = 1'b0;
  end
  // Clock rests low when not chosen, so no stray shifts reach the block
  always #400
  begin
    o_clk = i_run ? !o_clk : 1'b0;
    o_cascade = !o_cascade;
  end
endmodule

// file: sahi_top_props.sv
module sahi_top_props
  import sahi_pkg::*;
#(
  parameter int CONV_CYC = sahi_pkg::CONV_CYCLES
)(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_chip_select_n,
  input wire logic i_read_convert_n,
  input wire logic i_byte_select,
  input wire logic i_serial_clock_source_select,
  input wire logic i_analog_power_down,
  input wire logic i_reference_disable,
  input wire logic [sahi_pkg::BUS_W-1:0] o_parallel_line,
  input wire logic o_parallel_oe,
  input wire logic o_busy_n,
  input wire logic o_serial_bit_clock_oe,
  input wire logic o_analog_enable,
  input wire logic o_reference_enable
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Internal clock: busy also waits for the twelve-bit frame to finish
  localparam int SER_CYC = 2 * SCLK_HALF * RES_W + 1;
  localparam int BUSY_MIN = CONV_CYC;
  localparam int BUSY_LAST = CONV_CYC - 1;
  localparam int BUSY_MAX = (CONV_CYC > SER_CYC) ? CONV_CYC : SER_CYC;
  // Five cycles cover the input synchronisers
  a_bus_cs_float: assert property (i_chip_select_n [*5] |-> !o_parallel_oe) else $error("bus on, cs high");
  a_bus_rc_float: assert property (!i_read_convert_n [*5] |-> !o_parallel_oe) else $error("bus on, rc low");
  a_low_nibble: assert property (i_byte_select [*5] ##0 o_parallel_oe |-> o_parallel_line[3:0] == 4'h0)
    else $error("low lines not zero");
  a_bitclk_dir: assert property ($stable(i_serial_clock_source_select) [*5]
    |-> o_serial_bit_clock_oe == !i_serial_clock_source_select) else $error("bit clock direction");
  a_analog_en: assert property ($stable(i_analog_power_down) [*5]
    |-> o_analog_enable == !i_analog_power_down) else $error("analog enable");
  a_ref_en: assert property ($stable(i_reference_disable) [*5]
    |-> o_reference_enable == !i_reference_disable) else $error("reference enable");
  a_busy_hold: assert property ($fell(o_busy_n) |=> !o_busy_n [*8]) else $error("busy short");
  a_busy_len: assert property ($fell(o_busy_n) |-> ##[BUSY_MIN:BUSY_MAX] o_busy_n) else $error("busy length");
  a_busy_full: assert property ($fell(o_busy_n) |-> ##[BUSY_LAST:BUSY_LAST] !o_busy_n)
    else $error("busy ended early");
  a_start_cause: assert property ($fell(o_busy_n)
    |-> $past(!i_chip_select_n && !i_read_convert_n, 3)) else $error("start without request");
endmodule
bind sahi_top sahi_top_props #(.CONV_CYC(CONV_CYC)) u_props (.*);

// file: sahi_top_tb.sv
module sahi_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sahi_pkg::*;
  logic i_ref_clk = 0, i_resetn = 0, i_chip_select_n = 1, i_read_convert_n = 1, i_byte_select = 0;
  logic i_output_format_select = 0, i_serial_clock_source_select = 0, i_analog_power_down = 0;
  logic i_reference_disable = 0, i_serial_bit_clock, i_cascade_in;
  logic [11:0] i_sample = 0, ex, prev = 0, sh = 0;
  logic [7:0] o_parallel_line;
  logic o_parallel_oe, o_busy_n, o_serial_bit_clock, o_serial_bit_clock_oe, o_serial_result_out;
  logic o_analog_enable, o_reference_enable;
  int seed = 32'ha1fe, mismatches = 0, num_checks = 0, n, bits = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  sahi_top #(.CONV_CYC(60)) u_sahi_top (.*);
  sahi_host_clk u_sahi_host_clk (.i_run(i_serial_clock_source_select), .o_clk(i_serial_bit_clock),
    .o_cascade(i_cascade_in));
  ////////////////////////////////////////////////////////////////
  always @(negedge o_busy_n) bits = 0;
  always @(posedge o_serial_bit_clock)
  begin
    sh = {sh[10:0], o_serial_result_out};
    bits++;
  end
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wt(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask
  function automatic logic [11:0] code(input logic [11:0] s, input logic f);
    return f ? s ^ 12'h800 : s;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial
  begin
    wt(6);
    i_resetn = 1;
    wt(2);
    for (int i = 0; i < 8; i++)
    begin
      {i_serial_clock_source_select, i_output_format_select} = i[1:0];
      i_analog_power_down = 1'($random(seed));
      i_reference_disable = 1'($random(seed));
      i_sample = i == 7 ? 12'h800 : 12'($random(seed));
      if (i[2]) i_read_convert_n = 0;
      else i_chip_select_n = 0;
      wt(1);
      {i_chip_select_n, i_read_convert_n} = 2'b00;
      wt(6);
      chk(o_busy_n === 1'b0, "busy not low");
      i_read_convert_n = 1;
      wt(4);
      i_read_convert_n = 0;
      wt(4);
      i_read_convert_n = 1;
      n = 0;
      while (o_busy_n !== 1'b1 && n < 300)
      begin
        wt(1);
        n++;
      end
      chk(n > 30 && n < 300, "conversion time");
      ex = code(i_sample, i_output_format_select);
      chk(o_parallel_line === ex[11:4], "data late at busy rise");
      if (!i_serial_clock_source_select) chk(sh === prev && bits == 12, "serial frame");
      wt(4);
      chk(o_busy_n === 1'b1, "request during busy kept");
      chk(o_parallel_oe === 1'b1 && o_parallel_line === ex[11:4], "high byte");
      i_byte_select = 1;
      wt(4);
      chk(o_parallel_line === {ex[3:0], 4'h0}, "low byte");
      i_byte_select = 0;
      i_chip_select_n = 1;
      wt(4);
      chk(o_parallel_oe === 1'b0, "bus not released");
      prev = ex;
      $display("test %0d done", i);
    end
    print_verdict;
  end
  // Whole run is near 62 us, so this limit only trips on a hang
  initial
  begin
    #1ms;
    mismatches++;
    print_verdict;
  end
endmodule
